// File: logic/tcr_params.svh
// Operation
// - Three config bytes at 0x00-0x02, SPI read/write
// - Power-on loads 0x91, 0x10, 0x30
// - Soft reset bit resets all, self-clears
// - Switch polarity inverts antenna switch levels
// - Undervolt detect enable, cleared at power-on
// - Low-voltage status: read-only, sticky, read-clears
// - Data clock output gated low when disabled
// - Frequency-register mode selects one or two registers
// - Modulation bit: 0 on/off, 1 FSK
// - Data rate sets data and average cutoffs
// - Transceiver enable low keeps device in standby
// - Data manager enable bit switches data manager
// - Wakeup oscillator enable bit switches strobe oscillator
// - Lock-lost flag reads synthesiser out-of-lock state
// - Input attenuation 0, 8, 16, 30 dB
// - Output attenuation 0, 8, 16, 25 dB
// - Override picks average cutoff from filter field
// - Override bit chooses data-rate or filter field
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// ==========================================================
// Register map
`define TCR_ADDR_W           7
`define TCR_ADDR_CFG1        7'h00
`define TCR_ADDR_CFG2        7'h01
`define TCR_ADDR_CFG3        7'h02
`define TCR_RST_CFG1         8'h91
`define TCR_RST_CFG2         8'h10
`define TCR_RST_CFG3         8'h30

// ==========================================================
// Field positions
`define TCR_CFG1_SOFT_RST    3
`define TCR_CFG3_LOCK_LOST   5
`define TCR_CFG3_UNDERVOLT   4
`define TCR_CFG3_RW_MASK     8'hCF

// ==========================================================
// Decode figures
`define TCR_DATA_CUT_BASE_KHZ 6'h06
`define TCR_AVG_CUT_BASE_HZ   13'h01F4
`define TCR_IN_ATTEN_MAX_DB   5'h1E
`define TCR_OUT_ATTEN_MAX_DB  5'h19
`define TCR_ATTEN_STEP_DB     5'h08
`define TCR_SPI_BITS          4'h7

`endif

// File: logic/tcr_pkg.sv
`default_nettype none
package tcr_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } tcr_bus_type;

  typedef struct packed {
    logic [1:0] band_offset_sel;
    logic [1:0] band_sel;
    logic       switch_polarity;
    logic       undervolt_detect_en;
    logic       data_clock_out_en;
    logic       slicer_ref_sel;
    logic       freq_reg_mode;
    logic       modulation_sel;
    logic [1:0] data_rate_sel;
    logic       transceiver_en;
    logic       data_manager_en;
    logic       wakeup_osc_en;
    logic [1:0] avg_filter_sel;
    logic [1:0] input_atten_sel;
    logic [1:0] output_atten_sel;
  } tcr_cfg_type;

  typedef struct packed {
    logic [5:0]  data_cut_khz;
    logic [12:0] avg_cut_hz;
    logic [4:0]  in_atten_db;
    logic [4:0]  out_atten_db;
  } tcr_cut_type;

  typedef enum logic [1:0] {SPI_ADDR, SPI_DATA, SPI_DONE} tcr_spi_state_type;

endpackage
`default_nettype wire

// File: logic/tcr_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcr_params.svh"
module tcr_spi_slave
  import tcr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_en_i,
  input  wire logic        spi_sel_n_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_mosi_i,
  input  wire logic [7:0]  rd_data_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  output tcr_bus_type      bus_o
);

  // ==========================================================
  // Edge detect, pins already synchronous
  logic              sclk_q_r;
  logic              rise;
  logic              fall;
  logic [3:0]        cnt_r;
  logic [7:0]        sh_in_r;
  logic [7:0]        sh_out_r;
  logic [7:0]        byte_nxt;
  logic              write_r;
  tcr_spi_state_type state_r;
  tcr_bus_type       bus_r;

  assign rise     = spi_sclk_i & ~sclk_q_r;
  assign fall     = ~spi_sclk_i & sclk_q_r;
  assign byte_nxt = {sh_in_r[6:0], spi_mosi_i};

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sclk_q_r <= 1'b0;
    end else if (clk_en_i) begin
      sclk_q_r <= spi_sclk_i;
    end
  end

  // ==========================================================
  // Frame sequencing: one address byte, one data byte
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_r <= SPI_ADDR;
      cnt_r   <= 4'h0;
      sh_in_r <= 8'h00;
      write_r <= 1'b0;
      bus_r   <= '0;
    end else if (clk_en_i) begin
      bus_r.wr <= 1'b0;
      bus_r.rd <= 1'b0;
      if (spi_sel_n_i) begin
        state_r <= SPI_ADDR;
        cnt_r   <= 4'h0;
      end else if (rise && state_r != SPI_DONE) begin
        sh_in_r <= byte_nxt;
        cnt_r   <= (cnt_r == `TCR_SPI_BITS) ? 4'h0 : cnt_r + 4'h1;
        if (cnt_r == `TCR_SPI_BITS) begin
          unique case (state_r)
            SPI_ADDR: begin
              state_r    <= SPI_DATA;
              write_r    <= byte_nxt[7];
              bus_r.addr <= byte_nxt[6:0];
              bus_r.rd   <= ~byte_nxt[7];
            end
            SPI_DATA: begin
              state_r     <= SPI_DONE;
              bus_r.wr    <= write_r;
              bus_r.wdata <= byte_nxt;
            end
            SPI_DONE: begin
              state_r <= SPI_DONE;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Read data: loaded a cycle after the address byte
  // Shift only after a sampled bit, so the MSB survives
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sh_out_r <= 8'h00;
    end else if (clk_en_i) begin
      if (bus_r.rd) begin
        sh_out_r <= rd_data_i;
      end else if (fall && state_r == SPI_DATA && cnt_r != 4'h0) begin
        sh_out_r <= {sh_out_r[6:0], 1'b0};
      end
    end
  end

  assign spi_miso_o    = sh_out_r[7];
  assign spi_miso_oe_o = ~spi_sel_n_i & (state_r == SPI_DATA) & ~write_r;
  assign bus_o         = bus_r;

endmodule
`default_nettype wire

// File: logic/tcr_cutoff_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcr_params.svh"
module tcr_cutoff_decode
  import tcr_pkg::*;
(
  input  wire tcr_cfg_type cfg_i,
  input  wire logic        avg_filter_override_i,
  output tcr_cut_type      cut_o
);

  logic [1:0] avg_code;

  // ==========================================================
  // Cutoffs double per code step
  assign avg_code = avg_filter_override_i ? cfg_i.avg_filter_sel : cfg_i.data_rate_sel;
  assign cut_o.data_cut_khz = 6'(`TCR_DATA_CUT_BASE_KHZ << cfg_i.data_rate_sel);
  assign cut_o.avg_cut_hz   = 13'(`TCR_AVG_CUT_BASE_HZ << avg_code);

  // ==========================================================
  // Top attenuation step is not linear
  assign cut_o.in_atten_db  = (cfg_i.input_atten_sel == 2'h3) ? `TCR_IN_ATTEN_MAX_DB
                              : 5'(`TCR_ATTEN_STEP_DB * cfg_i.input_atten_sel);
  assign cut_o.out_atten_db = (cfg_i.output_atten_sel == 2'h3) ? `TCR_OUT_ATTEN_MAX_DB
                              : 5'(`TCR_ATTEN_STEP_DB * cfg_i.output_atten_sel);

endmodule
`default_nettype wire

// File: logic/tcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcr_params.svh"
module tcr_config_regs
  import tcr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        clk_en_i,
  input  wire logic        spi_sel_n_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic        pll_out_of_lock_i,
  input  wire logic        low_voltage_event_i,
  input  wire logic        transmitting_i,
  input  wire logic        data_clock_i,
  input  wire logic        avg_filter_override_i,
  output logic             antenna_switch_o,
  output logic             data_clock_o,
  output logic             soft_reset_o,
  output logic             standby_o,
  output logic             fsk_mode_o,
  output logic             two_freq_regs_o,
  output logic             data_manager_on_o,
  output logic             wakeup_osc_on_o,
  output logic             undervolt_detect_on_o,
  output tcr_cfg_type      cfg_o,
  output tcr_cut_type      cut_o
);

  // ==========================================================
  // Declarations
  tcr_bus_type bus;
  logic [7:0]  cfg1_r;
  logic [7:0]  cfg2_r;
  logic [7:0]  cfg3_r;
  logic        undervolt_r;
  logic        soft_rst_r;
  logic        soft_rst;
  logic [7:0]  rd_data;
  logic        status_read;
  logic        undervolt_set;
  tcr_cfg_type cfg;
  tcr_cut_type cut;
  tcr_cut_type cut_r;
  logic        switch_r;
  logic        dclk_r;

  // ==========================================================
  // Register port
  tcr_spi_slave u_spi (
    .clock_i       (clock_i),
    .nrst_i        (nrst_i),
    .clk_en_i      (clk_en_i),
    .spi_sel_n_i   (spi_sel_n_i),
    .spi_sclk_i    (spi_sclk_i),
    .spi_mosi_i    (spi_mosi_i),
    .rd_data_i     (rd_data),
    .spi_miso_o    (spi_miso_o),
    .spi_miso_oe_o (spi_miso_oe_o),
    .bus_o         (bus)
  );

  // Soft reset acts at once on the write that carries it
  assign soft_rst = bus.wr && bus.addr == `TCR_ADDR_CFG1 && bus.wdata[`TCR_CFG1_SOFT_RST];

  // ==========================================================
  // Writable configuration
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cfg1_r <= `TCR_RST_CFG1;
      cfg2_r <= `TCR_RST_CFG2;
      cfg3_r <= `TCR_RST_CFG3 & `TCR_CFG3_RW_MASK;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        cfg1_r <= `TCR_RST_CFG1;
        cfg2_r <= `TCR_RST_CFG2;
        cfg3_r <= `TCR_RST_CFG3 & `TCR_CFG3_RW_MASK;
      end else if (bus.wr) begin
        unique case (bus.addr)
          `TCR_ADDR_CFG1: cfg1_r <= bus.wdata & ~(8'h01 << `TCR_CFG1_SOFT_RST);
          `TCR_ADDR_CFG2: cfg2_r <= bus.wdata;
          `TCR_ADDR_CFG3: cfg3_r <= bus.wdata & `TCR_CFG3_RW_MASK;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Soft reset pulse for counters outside
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      soft_rst_r <= 1'b0;
    end else if (clk_en_i) begin
      soft_rst_r <= soft_rst;
    end
  end

  // ==========================================================
  // Low-voltage status: a new event beats the read clear
  assign status_read   = bus.rd && bus.addr == `TCR_ADDR_CFG3;
  assign undervolt_set = cfg.undervolt_detect_en & low_voltage_event_i;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      undervolt_r <= 1'b1;
    end else if (clk_en_i) begin
      if (soft_rst || undervolt_set) begin
        undervolt_r <= 1'b1;
      end else if (status_read) begin
        undervolt_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read mux, unmapped reads as zero
  always_comb begin
    unique case (bus.addr)
      `TCR_ADDR_CFG1: rd_data = cfg1_r;
      `TCR_ADDR_CFG2: rd_data = cfg2_r;
      `TCR_ADDR_CFG3: begin
        rd_data = cfg3_r;
        rd_data[`TCR_CFG3_LOCK_LOST] = pll_out_of_lock_i;
        rd_data[`TCR_CFG3_UNDERVOLT] = undervolt_r;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Field view
  assign cfg.band_offset_sel     = cfg1_r[7:6];
  assign cfg.band_sel            = cfg1_r[5:4];
  assign cfg.switch_polarity     = cfg1_r[2];
  assign cfg.undervolt_detect_en = cfg1_r[1];
  assign cfg.data_clock_out_en   = cfg1_r[0];
  assign cfg.slicer_ref_sel      = cfg2_r[7];
  assign cfg.freq_reg_mode       = cfg2_r[6];
  assign cfg.modulation_sel      = cfg2_r[5];
  assign cfg.data_rate_sel       = cfg2_r[4:3];
  assign cfg.transceiver_en      = cfg2_r[2];
  assign cfg.data_manager_en     = cfg2_r[1];
  assign cfg.wakeup_osc_en       = cfg2_r[0];
  assign cfg.avg_filter_sel      = cfg3_r[7:6];
  assign cfg.input_atten_sel     = cfg3_r[3:2];
  assign cfg.output_atten_sel    = cfg3_r[1:0];

  // ==========================================================
  // Analog settings, registered so outputs come from flops
  tcr_cutoff_decode u_dec (
    .cfg_i                 (cfg),
    .avg_filter_override_i (avg_filter_override_i),
    .cut_o                 (cut)
  );

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cut_r <= '0;
    end else if (clk_en_i) begin
      cut_r <= cut;
    end
  end

  // ==========================================================
  // Pin drivers; one cycle of delay on the data clock
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      switch_r <= 1'b0;
      dclk_r   <= 1'b0;
    end else if (clk_en_i) begin
      switch_r <= transmitting_i ^ cfg.switch_polarity;
      dclk_r   <= data_clock_i & cfg.data_clock_out_en;
    end
  end

  assign antenna_switch_o      = switch_r;
  assign data_clock_o          = dclk_r;
  assign soft_reset_o          = soft_rst_r;
  assign standby_o             = ~cfg.transceiver_en;
  assign fsk_mode_o            = cfg.modulation_sel;
  assign two_freq_regs_o       = cfg.freq_reg_mode;
  assign data_manager_on_o     = cfg.data_manager_en;
  assign wakeup_osc_on_o       = cfg.wakeup_osc_en;
  assign undervolt_detect_on_o = cfg.undervolt_detect_en;
  assign cfg_o                 = cfg;
  assign cut_o                 = cut_r;

endmodule
`default_nettype wire

// File: tb/tcr_config_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_config_regs_monitor
  import tcr_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        transmitting_i,
  input wire logic        data_clock_i,
  input wire logic        avg_filter_override_i,
  input wire logic        antenna_switch_o,
  input wire logic        data_clock_o,
  input wire logic        soft_reset_o,
  input wire logic        standby_o,
  input wire logic        fsk_mode_o,
  input wire logic        two_freq_regs_o,
  input wire logic        data_manager_on_o,
  input wire logic        wakeup_osc_on_o,
  input wire logic        undervolt_detect_on_o,
  input wire tcr_cfg_type cfg_o,
  input wire tcr_cut_type cut_o
);
  // ==========================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_standby_map: assert property (standby_o == !cfg_o.transceiver_en) else $error("standby level wrong");
  a_fsk_map: assert property (fsk_mode_o == cfg_o.modulation_sel) else $error("fsk level wrong");
  a_two_freq_map: assert property (two_freq_regs_o == cfg_o.freq_reg_mode) else $error("freq mode wrong");
  a_enable_map: assert property (
    {data_manager_on_o, wakeup_osc_on_o} == {cfg_o.data_manager_en, cfg_o.wakeup_osc_en})
    else $error("enable levels wrong");
  a_undervolt_map: assert property (undervolt_detect_on_o == cfg_o.undervolt_detect_en) else $error("detect level wrong");
  a_switch_level: assert property (
    $past(nrst_i) |-> antenna_switch_o == ($past(transmitting_i) ^ $past(cfg_o.switch_polarity)))
    else $error("antenna switch wrong");
  a_clock_gate: assert property (
    $past(nrst_i) |-> data_clock_o == ($past(data_clock_i) & $past(cfg_o.data_clock_out_en)))
    else $error("data clock gate wrong");
  a_soft_reload: assert property (
    soft_reset_o |=> !soft_reset_o && cfg_o.data_rate_sel == 2'h2 && !cfg_o.transceiver_en)
    else $error("soft reset wrong");
  a_data_cut: assert property (
    $past(nrst_i) |-> cut_o.data_cut_khz == (6'h06 << $past(cfg_o.data_rate_sel)))
    else $error("data cutoff wrong");
  a_avg_cut: assert property (
    $past(nrst_i) |-> cut_o.avg_cut_hz == (13'h01F4 << ($past(avg_filter_override_i) ?
    $past(cfg_o.avg_filter_sel) : $past(cfg_o.data_rate_sel)))) else $error("average cutoff wrong");
  a_atten_db: assert property (
    $past(nrst_i) |-> cut_o.in_atten_db == ($past(cfg_o.input_atten_sel) == 2'h3 ? 5'h1E :
    {$past(cfg_o.input_atten_sel), 3'h0}) && cut_o.out_atten_db == ($past(cfg_o.output_atten_sel) == 2'h3 ? 5'h19 :
    {$past(cfg_o.output_atten_sel), 3'h0})) else $error("attenuation wrong");
endmodule
bind tcr_config_regs tcr_config_regs_monitor tcr_config_regs_monitor_i (
  .clock_i               (clock_i),
  .nrst_i                (nrst_i),
  .transmitting_i        (transmitting_i),
  .data_clock_i          (data_clock_i),
  .avg_filter_override_i (avg_filter_override_i),
  .antenna_switch_o      (antenna_switch_o),
  .data_clock_o          (data_clock_o),
  .soft_reset_o          (soft_reset_o),
  .standby_o             (standby_o),
  .fsk_mode_o            (fsk_mode_o),
  .two_freq_regs_o       (two_freq_regs_o),
  .data_manager_on_o     (data_manager_on_o),
  .wakeup_osc_on_o       (wakeup_osc_on_o),
  .undervolt_detect_on_o (undervolt_detect_on_o),
  .cfg_o                 (cfg_o),
  .cut_o                 (cut_o)
);
`default_nettype wire

// File: tb/tcr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_spi_host (
  input  wire logic clock_i,
  input  wire logic spi_miso_i,
  output logic      spi_sel_n_o,
  output logic      spi_sclk_o,
  output logic      spi_mosi_o
);
  initial begin
    spi_sel_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
  end
  // ==========================================
  // One frame: command byte then data byte
  // Four-cycle phases keep a margin over the two-cycle minimum
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    sh = {wr, a, d};
    q = 8'h00;
    spi_sel_n_o <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (wr || i < 8) begin
        spi_mosi_o <= sh[15-i];
      end else begin
        spi_mosi_o <= ~spi_mosi_o;
      end
      repeat (4) @(posedge clock_i);
      if (i >= 8) begin
        q = {q[6:0], spi_miso_i};
      end
      spi_sclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      spi_sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clock_i);
    spi_sel_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o;
    repeat (4) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_tcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tcr_config_regs
  import tcr_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sel_n, sclk, mosi, miso, miso_oe;
  logic        pll = 1'b1, lve = 1'b0, tx = 1'b0, dclk = 1'b0, ovr = 1'b0;
  logic        ant, dclk_o, srst, stby, fsk, two_f, dm, osc, uvd;
  tcr_cfg_type cfg;
  tcr_cut_type cut;
  logic [1:0]  af;
  logic [12:0] in_db [4] = '{13'h0000, 13'h0008, 13'h0010, 13'h001E};
  logic [12:0] out_db [4] = '{13'h0000, 13'h0008, 13'h0010, 13'h0019};
  int          fails = 0, n_tests = 0, sr_seen = 0, oe_seen = 0, cycles = 0;

  always #12.5 clock_i = ~clock_i;

  tcr_config_regs tcr_config_regs_i (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .spi_sel_n_i(sel_n),
    .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .pll_out_of_lock_i(pll),
    .low_voltage_event_i(lve), .transmitting_i(tx), .data_clock_i(dclk), .avg_filter_override_i(ovr),
    .antenna_switch_o(ant), .data_clock_o(dclk_o), .soft_reset_o(srst), .standby_o(stby), .fsk_mode_o(fsk),
    .two_freq_regs_o(two_f), .data_manager_on_o(dm), .wakeup_osc_on_o(osc), .undervolt_detect_on_o(uvd),
    .cfg_o(cfg), .cut_o(cut));
  tcr_spi_host tcr_spi_host_i (.clock_i(clock_i), .spi_miso_i(miso), .spi_sel_n_o(sel_n), .spi_sclk_o(sclk),
    .spi_mosi_o(mosi));

  // ==========================================
  // Checks and access tasks
  task automatic final_report;
    $display("mismatches %0d of %0d checks", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    tcr_spi_host_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    tcr_spi_host_i.xfer(1'b0, a, 8'h00, q);
    chk({5'h00, q}, {5'h00, e});
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (srst === 1'b1) sr_seen <= sr_seen + 1;
    if (miso_oe === 1'b1) oe_seen <= oe_seen + 1;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    rd_chk(7'h00, 8'h91);
    chk(13'(oe_seen), 13'h0040);
    rd_chk(7'h01, 8'h10);
    rd_chk(7'h02, 8'h30);
    rd_chk(7'h02, 8'h20);
    pll <= 1'b0;
    rd_chk(7'h02, 8'h00);
    wr(7'h02, 8'hFF);
    chk(13'(oe_seen), 13'h0140);
    rd_chk(7'h02, 8'hCF);
    wr(7'h05, 8'hA5);
    rd_chk(7'h05, 8'h00);
    wr(7'h01, 8'hEF);
    rd_chk(7'h01, 8'hEF);
    chk({8'h00, stby, fsk, two_f, dm, osc}, 13'h000F);
    wr(7'h01, 8'h10);
    chk({8'h00, stby, fsk, two_f, dm, osc}, 13'h0010);
    for (int k = 0; k < 4; k++) begin
      af = (k == 0) ? 2'h0 : 2'(k - 1);
      wr(7'h01, {3'h0, k[1:0], 3'h0});
      wr(7'h02, {af, 2'h0, k[1:0], k[1:0]});
      chk({7'h00, cut.data_cut_khz}, 13'h0006 << k);
      chk(cut.avg_cut_hz, 13'h01F4 << k);
      chk({8'h00, cut.in_atten_db}, in_db[k]);
      chk({8'h00, cut.out_atten_db}, out_db[k]);
      ovr <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk(cut.avg_cut_hz, 13'h01F4 << af);
      ovr <= 1'b0;
    end
    for (int s = 0; s < 4; s++) begin
      wr(7'h00, {4'h5, 1'b0, s[1], 1'b0, s[0]});
      for (int t = 0; t < 2; t++) begin
        tx <= t[0];
        dclk <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({11'h000, ant, dclk_o}, {11'h000, t[0] ^ s[1], s[0]});
      end
    end
    wr(7'h02, 8'h00);
    lve <= 1'b1;
    repeat (2) @(posedge clock_i);
    lve <= 1'b0;
    rd_chk(7'h02, 8'h00);
    wr(7'h00, 8'h52);
    chk({12'h000, uvd}, 13'h0001);
    lve <= 1'b1;
    repeat (2) @(posedge clock_i);
    lve <= 1'b0;
    rd_chk(7'h02, 8'h10);
    wr(7'h01, 8'hEF);
    wr(7'h00, 8'h08);
    chk(13'(sr_seen), 13'h0001);
    rd_chk(7'h00, 8'h91);
    rd_chk(7'h01, 8'h10);
    rd_chk(7'h02, 8'h10);
    wr(7'h00, 8'h00);
    rd_chk(7'h00, 8'h00);
    chk(13'(sr_seen), 13'h0001);
    final_report();
  end
endmodule
`default_nettype wire
